// ### cocr_cfg.svh
// Purpose: Offsets, reset values, field positions of the output control slice
// Assumes: Byte-wide registers on the serial port's internal write/read strobe
// Notes:   Definitions only
`ifndef COCR_CFG_SVH
`define COCR_CFG_SVH

// ==========================================================
// Register offsets
`define COCR_ADDR_SS2   8'h72
`define COCR_ADDR_SS3   8'h73
`define COCR_ADDR_RSV   8'h74
`define COCR_ADDR_GRP0  8'h75
`define COCR_ADDR_GRP1  8'h76
`define COCR_ADDR_GRP2  8'h77
`define COCR_ADDR_GRP3  8'h78

// ==========================================================
// Reset values
`define COCR_RST_SS2    8'h00
`define COCR_RST_SS3    8'h00
`define COCR_RST_RSV    8'h01
`define COCR_RST_GRP0   8'h03
`define COCR_RST_GRP1   8'h00
`define COCR_RST_GRP2   8'h00
`define COCR_RST_GRP3   8'h00
`define COCR_RST_OTHER  8'h00

// ==========================================================
// Field positions inside a group byte
`define COCR_MODE_HI    7
`define COCR_MODE_LO    6
`define COCR_RATE_HI    5
`define COCR_RATE_LO    4
`define COCR_INV_A      3
`define COCR_INV_B      2
`define COCR_ROUTE_A    1
`define COCR_ROUTE_B    0

`endif

// ### cocr_pkg.sv
// Purpose: Types shared by the output control slice
// Assumes: Nothing beyond the constant header
// Notes:   Pin vectors are ordered output zero, one, two, three, six
package cocr_pkg;

  // ==========================================================
  // Configuration bytes as held by the register bank
  typedef struct packed {
    logic [7:0] ss2;   // Spread reference divide slot 2
    logic [7:0] ss3;   // Spread reference divide slot 3
    logic [7:0] grp0;  // Group zero and route control
    logic [7:0] grp1;  // Group one control
    logic [7:0] grp2;  // Group two control
    logic [7:0] grp3;  // Group three control
  } cocr_cfg_t;

  // Register bank state
  typedef struct packed {
    cocr_cfg_t  cfg;    // Stored bytes
    logic [7:0] rdata;  // Registered read data
  } cocr_bank_t;

  // Output pin trio without the input leg
  typedef struct packed {
    logic [4:0] level;  // Driven level per output
    logic [4:0] oe_n;   // Low while the pin is driven
  } cocr_pins_t;

  // Output stage state
  typedef struct packed {
    logic       en_s1;  // Enable pin, first sync stage
    logic       en_s2;  // Enable pin, second sync stage
    cocr_pins_t pins;   // Registered pin drive
    logic [7:0] rate;   // Registered edge rate fields
  } cocr_state_t;

endpackage

// ### cocr_reg_bank.sv
// Purpose: Byte register bank for the output control slice
// Assumes: Write strobe and address come from serial port logic on clk_in
// Notes:   Read data is registered; unmapped reads return zero
`timescale 1ns/10ps
`include "cocr_cfg.svh"

module cocr_reg_bank
  import cocr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Register access
  input  wire logic       wr_en_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] rdata_out,
  // Stored configuration
  output cocr_cfg_t       cfg_out
);

  cocr_bank_t st_r;   // All state
  cocr_bank_t st_nxt; // Next state

  // ==========================================================
  // Read decode
  function automatic logic [7:0] read_byte(input cocr_cfg_t c, input logic [7:0] a);
    logic [7:0] v;
    v = `COCR_RST_OTHER;
    case (a)
      `COCR_ADDR_SS2:  v = c.ss2;
      `COCR_ADDR_SS3:  v = c.ss3;
      `COCR_ADDR_RSV:  v = `COCR_RST_RSV;
      `COCR_ADDR_GRP0: v = c.grp0;
      `COCR_ADDR_GRP1: v = c.grp1;
      `COCR_ADDR_GRP2: v = c.grp2;
      `COCR_ADDR_GRP3: v = c.grp3;
      default:         v = `COCR_RST_OTHER;
    endcase
    return v;
  endfunction

  // Next state: writes land on the addressed byte only
  always_comb begin
    st_nxt = st_r;
    if (wr_en_in) begin
      case (addr_in)
        `COCR_ADDR_SS2:  st_nxt.cfg.ss2  = wdata_in;
        `COCR_ADDR_SS3:  st_nxt.cfg.ss3  = wdata_in;
        `COCR_ADDR_GRP0: st_nxt.cfg.grp0 = wdata_in;
        `COCR_ADDR_GRP1: st_nxt.cfg.grp1 = wdata_in;
        `COCR_ADDR_GRP2: st_nxt.cfg.grp2 = wdata_in;
        `COCR_ADDR_GRP3: st_nxt.cfg.grp3 = wdata_in;
        default:         st_nxt.cfg      = st_r.cfg; // Reserved slot ignores writes
      endcase
    end
    st_nxt.rdata = read_byte(st_r.cfg, addr_in);
  end

  // State register with documented reset bytes
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r.cfg.ss2  <= `COCR_RST_SS2;
      st_r.cfg.ss3  <= `COCR_RST_SS3;
      st_r.cfg.grp0 <= `COCR_RST_GRP0;
      st_r.cfg.grp1 <= `COCR_RST_GRP1;
      st_r.cfg.grp2 <= `COCR_RST_GRP2;
      st_r.cfg.grp3 <= `COCR_RST_GRP3;
      st_r.rdata    <= `COCR_RST_OTHER;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_out = st_r.rdata;
  assign cfg_out   = st_r.cfg;

endmodule

// ### cocr_output_ctrl.sv
// Purpose: Output stage control: routing, enable modes, inversion of clock outputs
// Assumes: Post-divider clocks are produced by logic on clk_in
// Notes:   Pin drive is registered, one clk_in cycle behind the dividers and stored fields, three behind the enable pin
`timescale 1ns/10ps
`include "cocr_cfg.svh"

// Contract
// - Route A: outputs one/two own or shared divider
// - Route B: outputs three/six own or shared divider
// - Mode low bit 0 tristates; 01 low, 11 high
// - Group zero mode governs output zero only
// - Group one mode governs outputs one, two
// - Group three mode governs outputs three, six
// - Invert bit flips its output clock
module cocr_output_ctrl
  import cocr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Register access from the serial port
  input  wire logic       reg_wr_en_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  // Post-divider clocks
  input  wire logic       post_divider_one_in,
  input  wire logic       post_divider_two_in,
  input  wire logic       post_divider_three_in,
  input  wire logic       post_divider_six_in,
  // Global output enable pin
  input  wire logic       output_enable_in,
  // Clock output pins, order zero, one, two, three, six
  output logic      [4:0] clock_output_out,
  output logic      [4:0] clock_output_oe_n_out,
  // Edge rate fields for the pad drivers, groups zero to three
  output logic      [7:0] edge_rate_out
);

  cocr_cfg_t   cfg;    // Stored configuration
  cocr_state_t st_r;   // All state
  cocr_state_t st_nxt; // Next state

  // Aliases of the fields that steer the pins
  // Group two's inversion bits are stored but steer no pin
  logic [1:0] group_zero_enable_mode;
  logic [1:0] group_one_enable_mode;
  logic [1:0] group_three_enable_mode;
  logic       group_zero_invert;
  logic [1:0] group_one_invert;
  logic [1:0] group_three_invert;
  logic       pair_a_route_select;
  logic       pair_b_route_select;
  logic       src1;    // Source for output one
  logic       src3;    // Source for output three

  // ==========================================================
  // Register bank
  cocr_reg_bank u_bank (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .wr_en_in  (reg_wr_en_in),
    .addr_in   (reg_addr_in),
    .wdata_in  (reg_wdata_in),
    .rdata_out (reg_rdata_out),
    .cfg_out   (cfg)
  );

  assign group_zero_enable_mode  = cfg.grp0[`COCR_MODE_HI:`COCR_MODE_LO];
  assign group_one_enable_mode   = cfg.grp1[`COCR_MODE_HI:`COCR_MODE_LO];
  assign group_three_enable_mode = cfg.grp3[`COCR_MODE_HI:`COCR_MODE_LO];
  assign group_zero_invert       = cfg.grp0[`COCR_INV_A];
  assign group_one_invert        = cfg.grp1[`COCR_INV_A:`COCR_INV_B];
  assign group_three_invert      = cfg.grp3[`COCR_INV_A:`COCR_INV_B];
  assign pair_a_route_select     = cfg.grp0[`COCR_ROUTE_A];
  assign pair_b_route_select     = cfg.grp0[`COCR_ROUTE_B];

  // ==========================================================
  // Route selection
  // Shared divider when the select is clear
  assign src1 = pair_a_route_select ? post_divider_one_in : post_divider_two_in;
  assign src3 = pair_b_route_select ? post_divider_three_in : post_divider_six_in;

  // ==========================================================
  // Pin drive: returns {level, oe_n}
  function automatic logic [1:0] pin_drive(input logic en, input logic clk,
                                           input logic inv, input logic [1:0] mode);
    logic [1:0] r;
    r = 2'h1;
    if (en) begin
      r = {clk ^ inv, 1'b0};
    end else if (!mode[0]) begin
      r = 2'h1;
    end else begin
      r = {mode[1], 1'b0};
    end
    return r;
  endfunction

  // Next state: each output reads its own group's mode and invert fields; outputs one and three also read group zero's route bits
  always_comb begin
    logic [1:0] d0;
    logic [1:0] d1;
    logic [1:0] d2;
    logic [1:0] d3;
    logic [1:0] d6;
    d0 = pin_drive(st_r.en_s2, post_divider_one_in, group_zero_invert, group_zero_enable_mode);
    d1 = pin_drive(st_r.en_s2, src1, group_one_invert[1], group_one_enable_mode);
    d2 = pin_drive(st_r.en_s2, post_divider_two_in, group_one_invert[0], group_one_enable_mode);
    d3 = pin_drive(st_r.en_s2, src3, group_three_invert[1], group_three_enable_mode);
    d6 = pin_drive(st_r.en_s2, post_divider_six_in, group_three_invert[0], group_three_enable_mode);
    st_nxt            = st_r;
    // Enable pin passes two stages before any pin reads it
    st_nxt.en_s1      = output_enable_in;
    st_nxt.en_s2      = st_r.en_s1;
    st_nxt.pins.level = {d6[1], d3[1], d2[1], d1[1], d0[1]};
    st_nxt.pins.oe_n  = {d6[0], d3[0], d2[0], d1[0], d0[0]};
    // Edge rate fields pass through to the pad drivers
    st_nxt.rate       = {cfg.grp3[`COCR_RATE_HI:`COCR_RATE_LO], cfg.grp2[`COCR_RATE_HI:`COCR_RATE_LO],
                         cfg.grp1[`COCR_RATE_HI:`COCR_RATE_LO], cfg.grp0[`COCR_RATE_HI:`COCR_RATE_LO]};
  end

  // State register; pins float after reset until enabled or parked by their mode field
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r.en_s1      <= 1'b0;
      st_r.en_s2      <= 1'b0;
      st_r.pins.level <= 5'h00;
      st_r.pins.oe_n  <= 5'h1f;
      st_r.rate       <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Pins and edge rates come straight from the state register
  assign clock_output_out      = st_r.pins.level;
  assign clock_output_oe_n_out = st_r.pins.oe_n;
  assign edge_rate_out         = st_r.rate;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Pins are registered, so every check but enable_sync_a looks one edge back

  route_a_own_a : assert property (
    $past(st_r.en_s2) && $past(pair_a_route_select)
      |-> clock_output_out[1] == ($past(post_divider_one_in) ^ $past(group_one_invert[1])))
    else $error("output one not from its own divider");

  route_a_shared_a : assert property (
    $past(st_r.en_s2) && !$past(pair_a_route_select)
      |-> clock_output_out[1] == ($past(post_divider_two_in) ^ $past(group_one_invert[1])))
    else $error("output one not from shared divider");

  route_b_pair_a : assert property (
    $past(st_r.en_s2)
      |-> clock_output_out[3] == (($past(pair_b_route_select) ? $past(post_divider_three_in)
                                   : $past(post_divider_six_in)) ^ $past(group_three_invert[1])))
    else $error("output three source wrong");

  mode_tristate_a : assert property (
    !$past(st_r.en_s2) && !$past(group_one_enable_mode[0])
      |-> clock_output_oe_n_out[2:1] == 2'h3)
    else $error("group one not tristated");

  mode_park_a : assert property (
    !$past(st_r.en_s2) && $past(group_three_enable_mode[0])
      |-> clock_output_oe_n_out[4:3] == 2'h0 &&
          clock_output_out[4:3] == {2{$past(group_three_enable_mode[1])}})
    else $error("group three park level wrong");

  group_zero_only_a : assert property (
    !$past(st_r.en_s2) && !st_r.en_s2 && $stable(group_one_enable_mode) && $stable(group_three_enable_mode)
      && $changed(group_zero_enable_mode) |=> $stable(clock_output_oe_n_out[4:1]))
    else $error("group zero mode disturbed other outputs");

  invert_six_a : assert property (
    $past(st_r.en_s2) |-> clock_output_out[4] == ($past(post_divider_six_in) ^ $past(group_three_invert[0])))
    else $error("output six inversion wrong");

  enable_sync_a : assert property (
    $rose(output_enable_in) ##1 output_enable_in ##1 output_enable_in |=> clock_output_oe_n_out == 5'h00)
    else $error("enabled outputs not driven after sync delay");

  // Enabled outputs: each pin follows its source one edge back
  out_zero_src_a : assert property (
    $past(st_r.en_s2) |-> clock_output_out[0] == ($past(post_divider_one_in) ^ $past(group_zero_invert)))
    else $error("output zero source or inversion wrong");

  out_two_src_a : assert property (
    $past(st_r.en_s2) |-> clock_output_out[2] == ($past(post_divider_two_in) ^ $past(group_one_invert[0])))
    else $error("output two source or inversion wrong");

  all_driven_a : assert property (
    $past(st_r.en_s2) |-> clock_output_oe_n_out == 5'h00)
    else $error("enabled output left floating");

  // Disabled outputs: mode fields decide float or park level
  zero_float_a : assert property (
    !$past(st_r.en_s2) && !$past(group_zero_enable_mode[0])
      |-> clock_output_oe_n_out[0] && !clock_output_out[0])
    else $error("output zero not tristated");

  zero_park_a : assert property (
    !$past(st_r.en_s2) && $past(group_zero_enable_mode[0])
      |-> !clock_output_oe_n_out[0] && clock_output_out[0] == $past(group_zero_enable_mode[1]))
    else $error("output zero park level wrong");

  one_park_a : assert property (
    !$past(st_r.en_s2) && $past(group_one_enable_mode[0])
      |-> clock_output_oe_n_out[2:1] == 2'h0 &&
          clock_output_out[2:1] == {2{$past(group_one_enable_mode[1])}})
    else $error("group one park level wrong");

  three_float_a : assert property (
    !$past(st_r.en_s2) && !$past(group_three_enable_mode[0])
      |-> clock_output_oe_n_out[4:3] == 2'h3)
    else $error("group three not tristated");

  // Mode change of group one leaves groups zero and three alone
  group_one_only_a : assert property (
    !$past(st_r.en_s2) && !st_r.en_s2 && $stable(group_zero_enable_mode) && $stable(group_three_enable_mode)
      && $changed(group_one_enable_mode) |=> $stable({clock_output_oe_n_out[4:3], clock_output_oe_n_out[0]}))
    else $error("group one mode disturbed other outputs");

endmodule

// ### cocr_load_model.sv
// Purpose: Loads on the clock output pins
// Assumes: Pin drive is registered on clk_in
// Notes:   A released pin shows the inverse of its last driven level
`timescale 1ns/10ps
module cocr_load_model (
  // Clock
  input  wire logic       clk_in,
  // Pin drive
  input  wire logic [4:0] level_in,
  input  wire logic [4:0] oe_n_in,
  // Wire levels
  output logic      [4:0] pin_out
);
  logic [4:0] last_r = 5'h00; // Last driven level
  // ==========
  // Remember the level each pin was last driven to
  always @(posedge clk_in) begin
    for (int i = 0; i < 5; i++) begin
      if (!oe_n_in[i]) begin
        last_r[i] <= level_in[i];
      end
    end
  end
  // Driven pins follow, released pins show the inverse of their last drive
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pin_out[i] = oe_n_in[i] ? ~last_r[i] : level_in[i];
    end
  end
endmodule

// ### cocr_output_ctrl_bench.sv
// Purpose: Self-checking bench of the output control slice
// Assumes: Inputs change on the falling edge
// Notes:   Reset checks first, then register reads, then rows, then hand tests
`timescale 1ns/10ps
module cocr_output_ctrl_bench;
  import cocr_pkg::*;
  // Row: config bytes, enable pin, dividers {six,three,two,one}, expected levels and oe_n
  typedef struct packed {
    logic [7:0] g0, g1, g2, g3;
    logic en;
    logic [3:0] dv;
    logic [4:0] xl, xo;
  } cocr_row_t;
  logic       clk_in, rst_in, wr, en;
  logic [7:0] addr, wd, rdata, rate;
  logic [3:0] dv;
  logic [4:0] lvl, oe_n, pin;
  int         bad_count, n_checks, cyc;
  logic [9:0] e;
  cocr_row_t  rows [8] = '{
    '{8'h03, 8'h00, 8'h00, 8'h00, 1'b1, 4'h5, 5'h0b, 5'h00},
    '{8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 4'h5, 5'h01, 5'h00},
    '{8'h08, 8'h0c, 8'h00, 8'h0c, 1'b1, 4'ha, 5'h01, 5'h00},
    '{8'h0b, 8'h04, 8'h00, 8'h08, 1'b1, 4'h3, 5'h0a, 5'h00},
    '{8'h00, 8'h00, 8'h00, 8'h40, 1'b0, 4'hf, 5'h00, 5'h07},
    '{8'h40, 8'hc0, 8'h00, 8'h80, 1'b0, 4'h0, 5'h06, 5'h18},
    '{8'hc0, 8'h40, 8'h00, 8'hc0, 1'b0, 4'hf, 5'h19, 5'h00},
    '{8'h70, 8'h20, 8'h30, 8'hd0, 1'b0, 4'h0, 5'h18, 5'h06}};
  logic [7:0] rst_vals [9] = '{8'h00, 8'h00, 8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // ==========
  // Design and loads
  cocr_output_ctrl DUT (.clk_in(clk_in), .rst_in(rst_in), .reg_wr_en_in(wr), .reg_addr_in(addr),
    .reg_wdata_in(wd), .reg_rdata_out(rdata), .post_divider_one_in(dv[0]), .post_divider_two_in(dv[1]),
    .post_divider_three_in(dv[2]), .post_divider_six_in(dv[3]), .output_enable_in(en),
    .clock_output_out(lvl), .clock_output_oe_n_out(oe_n), .edge_rate_out(rate));
  cocr_load_model LOAD (.clk_in(clk_in), .level_in(lvl), .oe_n_in(oe_n), .pin_out(pin));
  // Clock, 25 ns period
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  // Compare and count
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One byte write
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    wr = 1'b1;
    addr = a;
    wd = d;
    @(negedge clk_in);
    wr = 1'b0;
  endtask
  // One byte read, compared
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_in);
    addr = a;
    @(negedge clk_in);
    check("rdata", rdata, exp);
  endtask
  // Expected {level, oe_n}; tristated levels shown as 0
  function automatic logic [9:0] exp_pins(input cocr_row_t r);
    logic [4:0] s, iv, lv, oe;
    logic [1:0] md [5];
    s = {r.dv[3], r.g0[0] ? r.dv[2] : r.dv[3], r.dv[1], r.g0[1] ? r.dv[0] : r.dv[1], r.dv[0]};
    iv = {r.g3[2], r.g3[3], r.g1[2], r.g1[3], r.g0[3]};
    md = '{r.g0[7:6], r.g1[7:6], r.g1[7:6], r.g3[7:6], r.g3[7:6]};
    for (int i = 0; i < 5; i++) begin
      oe[i] = !r.en && !md[i][0];
      lv[i] = r.en ? s[i] ^ iv[i] : md[i][1] && !oe[i];
    end
    return {lv, oe};
  endfunction
  // Closing report
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      end_sim();
    end
  end
  // Main sequence
  initial begin
    {rst_in, wr, en, addr, wd, dv} = {1'b1, 2'b00, 8'h00, 8'h00, 4'h0};
    repeat (12) @(posedge clk_in);
    @(negedge clk_in);
    check("oe_n_rst", {3'h0, oe_n}, 8'h1f);
    check("rate_rst", rate, 8'h00);
    rst_in = 1'b0;
    for (int i = 0; i < 9; i++) rd_reg(8'h72 + 8'(i), rst_vals[i]);
    wr_reg(8'h74, 8'hff);
    wr_reg(8'h79, 8'hff);
    rd_reg(8'h74, 8'h01);
    rd_reg(8'h79, 8'h00);
    $display("registers done");
    foreach (rows[i]) begin
      wr_reg(8'h75, rows[i].g0);
      wr_reg(8'h76, rows[i].g1);
      wr_reg(8'h77, rows[i].g2);
      wr_reg(8'h78, rows[i].g3);
      en = rows[i].en;
      dv = rows[i].dv;
      repeat (4) @(negedge clk_in);
      e = exp_pins(rows[i]);
      check("oe_n", {3'h0, oe_n}, {3'h0, e[4:0]});
      check("level", {3'h0, pin & ~e[4:0]}, {3'h0, e[9:5]});
      check("row_oe_n", {3'h0, oe_n}, {3'h0, rows[i].xo});
      check("row_level", {3'h0, pin & ~rows[i].xo}, {3'h0, rows[i].xl});
      check("rate", rate, {rows[i].g3[5:4], rows[i].g2[5:4], rows[i].g1[5:4], rows[i].g0[5:4]});
      rd_reg(8'h75, rows[i].g0);
      $display("row %0d done", i);
    end
    wr_reg(8'h75, 8'h00);
    wr_reg(8'h76, 8'h0c);
    wr_reg(8'h78, 8'h00);
    en = 1'b1;
    repeat (2) @(negedge clk_in);
    check("oe_n_sync", {3'h0, oe_n}, 8'h1f);
    @(negedge clk_in);
    check("oe_n_on", {3'h0, oe_n}, 8'h00);
    for (int t = 0; t < 8; t++) begin
      dv = {2'b00, t[0], ~t[0]};
      @(negedge clk_in);
      check("live", {5'h0, pin[2:0]}, {5'h0, {3{~t[0]}}});
    end
    $display("live clock done");
    rst_in = 1'b1;
    @(negedge clk_in);
    check("oe_n_rst2", {3'h0, oe_n}, 8'h1f);
    rst_in = 1'b0;
    rd_reg(8'h76, 8'h00);
    $display("reset done");
    end_sim();
  end
endmodule
